//--- hdl/act_top.sv
// Converter control and trigger block: registers, start/complete sequencing, result formatting.
// Assumes an analog core that takes start and tad ticks and answers with done plus a result.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module act_top (
	// Clock and reset
	input  wire logic                             clk,
	input  wire logic                             nrst,
	// Register port
	input  wire logic [7:0]                       addr,
	input  wire logic [7:0]                       wdata,
	input  wire logic                             wr,
	input  wire logic                             rd,
	output logic      [7:0]                       rdata,
	// System status
	input  wire logic                             ext_osc_sel,
	input  wire logic                             sleep,
	input  wire logic                             rc_osc_clk,
	// Trigger sources
	input  wire logic [act_pkg::ACT_TRIG_NUM-1:0] trig_src,
	// Analog core
	output act_pkg::act_core_req_t                core_req,
	input  wire act_pkg::act_core_rsp_t           core_rsp,
	output act_pkg::act_route_t                   route,
	output act_pkg::act_ref_t                     ref_sel,
	// Status out
	output logic                                  conversion_done_flag,
	output logic                                  busy
);
	import act_pkg::*;

	// ==========================================================
	// Declarations
	act_ctrl0_t ctrl0_r;
	act_ctrl1_t ctrl1_r;
	logic [4:0] trig_sel_r;
	logic [7:0] res_high_r;
	logic [7:0] res_low_r;
	logic       done_r;
	logic [7:0] rdata_r;
	act_state_t state_r;
	act_state_t state_nxt;
	logic [2:0] delay_r;
	logic       start_r;
	act_route_t route_r;
	logic       wr_ctrl0;
	logic       sw_start;
	logic       hw_start;
	logic       start_req;
	logic       complete;
	logic       abort;
	logic       use_rc;
	logic       tad_tick;
	logic       trig_pulse;

	// ==========================================================
	// Start, abort and completion terms
	assign wr_ctrl0 = wr && (addr == ACT_OFS_CTRL0);
	assign use_rc   = (ctrl1_r.conv_clock_select[1:0] == ACT_CS_RC_LO);

	// Go is honoured only if the converter was already on before this write
	assign sw_start = wr_ctrl0 && wdata[ACT_BIT_GO] && wdata[ACT_BIT_ON] &&
	                  ctrl0_r.converter_on;
	assign hw_start = trig_pulse && (state_r == ACT_ST_IDLE);
	assign start_req = (sw_start || hw_start) && (state_r == ACT_ST_IDLE);

	// Turning off, or sleeping without the RC clock, ends the conversion
	assign abort    = !ctrl0_r.converter_on || (sleep && !use_rc) ||
	                  (wr_ctrl0 && !wdata[ACT_BIT_ON]);
	assign complete = (state_r == ACT_ST_CONV) && core_rsp.done && !abort;

	// ==========================================================
	// Conversion clock and trigger helpers
	act_clkdiv u_clkdiv (
		.clk               (clk),
		.nrst              (nrst),
		.conv_clock_select (ctrl1_r.conv_clock_select),
		.run               (state_r == ACT_ST_CONV),
		.rc_osc_clk        (rc_osc_clk),
		.tad_tick          (tad_tick)
	);

	// Auto trigger is not available during sleep
	act_trig u_trig (
		.clk                 (clk),
		.nrst                (nrst),
		.auto_trigger_select (trig_sel_r),
		.allow               (ctrl0_r.converter_on && !sleep),
		.trig_src            (trig_src),
		.trig_pulse          (trig_pulse)
	);

	// ==========================================================
	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ACT_ST_IDLE: begin
				if (start_req && !abort) begin
					state_nxt = use_rc ? ACT_ST_DELAY : ACT_ST_CONV;
				end
			end
			ACT_ST_DELAY: begin
				if (abort) begin
					state_nxt = ACT_ST_IDLE;
				end else if (delay_r == 3'(ACT_INSTR_CYC - 1)) begin
					state_nxt = ACT_ST_CONV;
				end
			end
			ACT_ST_CONV: begin
				if (abort || core_rsp.done) begin
					state_nxt = ACT_ST_IDLE;
				end
			end
			default: begin
				state_nxt = ACT_ST_IDLE;
			end
		endcase
	end

	// Sequencer state
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ACT_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Instruction-cycle wait counter for the RC clock
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			delay_r <= 3'h0;
		end else if (state_r == ACT_ST_DELAY) begin
			delay_r <= delay_r + 3'h1;
		end else begin
			delay_r <= 3'h0;
		end
	end

	// One-cycle start toward the core as conversion begins
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			start_r <= 1'b0;
		end else begin
			start_r <= (state_r != ACT_ST_CONV) && (state_nxt == ACT_ST_CONV);
		end
	end

	// ==========================================================
	// Control register zero; hardware set and clear of go
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl0_r <= act_ctrl0_t'(ACT_RST_REG);
		end else begin
			if (wr_ctrl0) begin
				ctrl0_r.input_select <= wdata[7:2];
				ctrl0_r.converter_on <= wdata[ACT_BIT_ON];
			end
			if (start_req && !abort) begin
				ctrl0_r.convert_go <= 1'b1;
			end else if (complete || (state_r != ACT_ST_IDLE && state_nxt == ACT_ST_IDLE)) begin
				ctrl0_r.convert_go <= 1'b0;
			end else if (wr_ctrl0 && !wdata[ACT_BIT_GO]) begin
				ctrl0_r.convert_go <= 1'b0;
			end
		end
	end

	// Control register one and trigger select
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl1_r    <= act_ctrl1_t'(ACT_RST_REG);
			trig_sel_r <= ACT_TRIG_OFF;
		end else begin
			if (wr && addr == ACT_OFS_CTRL1) begin
				ctrl1_r <= act_ctrl1_t'(wdata & ACT_MASK_CTRL1);
			end
			if (wr && addr == ACT_OFS_TRIG) begin
				trig_sel_r <= wdata[4:0];
			end
		end
	end

	// ==========================================================
	// Result registers, formatted at load time
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			res_high_r <= ACT_RST_REG;
			res_low_r  <= ACT_RST_REG;
		end else if (complete) begin
			if (ctrl1_r.result_justify) begin
				res_high_r <= {6'h00, core_rsp.result[9:8]};
				res_low_r  <= core_rsp.result[7:0];
			end else begin
				res_high_r <= core_rsp.result[9:2];
				res_low_r  <= {core_rsp.result[1:0], 6'h00};
			end
		end else begin
			if (wr && addr == ACT_OFS_RES_HIGH) begin
				res_high_r <= wdata;
			end
			if (wr && addr == ACT_OFS_RES_LOW) begin
				res_low_r <= wdata;
			end
		end
	end

	// Done flag: completion wins over a software clear in the same cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			done_r <= 1'b0;
		end else if (complete) begin
			done_r <= 1'b1;
		end else if (wr && addr == ACT_OFS_FLAGS) begin
			done_r <= wdata[ACT_BIT_DONE];
		end
	end

	// ==========================================================
	// Read data, valid the cycle after the strobe
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata_r <= ACT_RST_REG;
		end else if (rd) begin
			if (addr == ACT_OFS_CTRL0) begin
				rdata_r <= ctrl0_r;
			end else if (addr == ACT_OFS_CTRL1) begin
				rdata_r <= 8'(ctrl1_r) & ACT_MASK_CTRL1;
			end else if (addr == ACT_OFS_TRIG) begin
				rdata_r <= {3'h0, trig_sel_r} & ACT_MASK_TRIG;
			end else if (addr == ACT_OFS_RES_HIGH) begin
				rdata_r <= res_high_r;
			end else if (addr == ACT_OFS_RES_LOW) begin
				rdata_r <= res_low_r;
			end else if (addr == ACT_OFS_FLAGS) begin
				rdata_r <= {7'h00, done_r} & ACT_MASK_FLAGS;
			end else begin
				rdata_r <= 8'h00; // Unmapped reads as zero
			end
		end else begin
			rdata_r <= 8'h00;
		end
	end

	// ==========================================================
	// Channel routing; registered so the analog mux never glitches
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			route_r <= '{src: ACT_SRC_NONE, pin: 3'h0};
		end else begin
			route_r <= '{src: ACT_SRC_NONE, pin: 3'h0};
			if (ctrl0_r.input_select <= ACT_CH_PA_LAST) begin
				// Pins 4 and 5 share the oscillator, so they drop out while ext_osc_sel is set
				if (!(ext_osc_sel && (ctrl0_r.input_select == ACT_CH_PA4 ||
				      ctrl0_r.input_select == ACT_CH_PA5))) begin
					route_r <= '{src: ACT_SRC_PORTA,
					             pin: ctrl0_r.input_select[2:0]};
				end
			end else if (ctrl0_r.input_select >= ACT_CH_PC_BASE &&
			             ctrl0_r.input_select <= ACT_CH_PC_LAST) begin
				route_r <= '{src: ACT_SRC_PORTC, pin: ctrl0_r.input_select[2:0]};
			end else if (ctrl0_r.input_select == ACT_CH_FVR2) begin
				route_r <= '{src: ACT_SRC_FVR2, pin: 3'h0};
			end else if (ctrl0_r.input_select == ACT_CH_FVR1) begin
				route_r <= '{src: ACT_SRC_FVR1, pin: 3'h0};
			end else if (ctrl0_r.input_select == ACT_CH_DAC) begin
				route_r <= '{src: ACT_SRC_DAC, pin: 3'h0};
			end else if (ctrl0_r.input_select == ACT_CH_TEMP) begin
				route_r <= '{src: ACT_SRC_TEMP, pin: 3'h0};
			end else if (ctrl0_r.input_select == ACT_CH_GND) begin
				route_r <= '{src: ACT_SRC_GND, pin: 3'h0};
			end
		end
	end

	// ==========================================================
	// Outputs
	assign route    = route_r;
	assign ref_sel  = act_ref_t'(ctrl1_r.pos_ref_select);
	assign rdata    = rdata_r;
	assign busy     = ctrl0_r.convert_go;
	assign conversion_done_flag = done_r;

	// Core request; powered follows the enable bit
	assign core_req.start    = start_r;
	assign core_req.tad_tick = tad_tick;
	assign core_req.powered  = ctrl0_r.converter_on;

endmodule : act_top

//--- hdl/act_pkg.sv
// Package: register map, field layouts, codes and timing for the converter control block.
// Assumes one 50 MHz system clock and an 8-bit register port with byte addresses.
package act_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [7:0] ACT_OFS_CTRL0    = 8'h00;
	localparam logic [7:0] ACT_OFS_CTRL1    = 8'h01;
	localparam logic [7:0] ACT_OFS_TRIG     = 8'h02;
	localparam logic [7:0] ACT_OFS_RES_HIGH = 8'h03;
	localparam logic [7:0] ACT_OFS_RES_LOW  = 8'h04;
	localparam logic [7:0] ACT_OFS_FLAGS    = 8'h05;

	// ==========================================================
	// Reset values and read masks
	localparam logic [7:0] ACT_RST_REG      = 8'h00;
	localparam logic [7:0] ACT_MASK_CTRL1   = 8'hF3;
	localparam logic [7:0] ACT_MASK_TRIG    = 8'h1F;
	localparam logic [7:0] ACT_MASK_FLAGS   = 8'h01;

	// ==========================================================
	// Field positions
	localparam int ACT_BIT_ON      = 0;
	localparam int ACT_BIT_GO      = 1;
	localparam int ACT_BIT_DONE    = 0;

	// ==========================================================
	// Trigger codes
	localparam logic [4:0] ACT_TRIG_OFF   = 5'h00;
	localparam logic [4:0] ACT_TRIG_CELL3 = 5'h11;
	localparam logic [4:0] ACT_TRIG_CELL4 = 5'h12;
	localparam int         ACT_TRIG_NUM   = 19;

	// ==========================================================
	// Channel codes
	localparam logic [5:0] ACT_CH_PA_BASE = 6'h00;
	localparam logic [5:0] ACT_CH_PA_LAST = 6'h05;
	localparam logic [5:0] ACT_CH_PA4     = 6'h04;
	localparam logic [5:0] ACT_CH_PA5     = 6'h05;
	localparam logic [5:0] ACT_CH_PC_BASE = 6'h10;
	localparam logic [5:0] ACT_CH_PC_LAST = 6'h15;
	localparam logic [5:0] ACT_CH_GND     = 6'h3B;
	localparam logic [5:0] ACT_CH_TEMP    = 6'h3C;
	localparam logic [5:0] ACT_CH_DAC     = 6'h3D;
	localparam logic [5:0] ACT_CH_FVR1    = 6'h3E;
	localparam logic [5:0] ACT_CH_FVR2    = 6'h3F;

	// ==========================================================
	// Conversion clock select codes
	localparam logic [2:0] ACT_CS_DIV2  = 3'h0;
	localparam logic [2:0] ACT_CS_DIV8  = 3'h1;
	localparam logic [2:0] ACT_CS_DIV32 = 3'h2;
	localparam logic [2:0] ACT_CS_DIV4  = 3'h4;
	localparam logic [2:0] ACT_CS_DIV16 = 3'h5;
	localparam logic [2:0] ACT_CS_DIV64 = 3'h6;
	localparam logic [1:0] ACT_CS_RC_LO = 2'h3;

	// ==========================================================
	// Timing: one instruction cycle, rounded up to system clocks
	localparam int ACT_CLK_NS     = 20;
	localparam int ACT_INSTR_NS   = 80;
	localparam int ACT_INSTR_CYC  = (ACT_INSTR_NS + ACT_CLK_NS - 1) / ACT_CLK_NS;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		ACT_SRC_NONE  = 4'h0,
		ACT_SRC_PORTA = 4'h1,
		ACT_SRC_PORTC = 4'h2,
		ACT_SRC_FVR2  = 4'h3,
		ACT_SRC_FVR1  = 4'h4,
		ACT_SRC_DAC   = 4'h5,
		ACT_SRC_TEMP  = 4'h6,
		ACT_SRC_GND   = 4'h7
	} act_src_t;

	typedef enum logic [1:0] {
		ACT_REF_SUPPLY = 2'h0,
		ACT_REF_RSVD   = 2'h1,
		ACT_REF_PIN    = 2'h2,
		ACT_REF_FIXED  = 2'h3
	} act_ref_t;

	typedef struct packed {
		act_src_t   src;
		logic [2:0] pin;
	} act_route_t;

	typedef struct packed {
		logic [5:0] input_select;
		logic       convert_go;
		logic       converter_on;
	} act_ctrl0_t;

	typedef struct packed {
		logic       result_justify;
		logic [2:0] conv_clock_select;
		logic [1:0] unused;
		logic [1:0] pos_ref_select;
	} act_ctrl1_t;

	typedef struct packed {
		logic       start;
		logic       tad_tick;
		logic       powered;
	} act_core_req_t;

	typedef struct packed {
		logic       done;
		logic [9:0] result;
	} act_core_rsp_t;

	typedef enum logic [1:0] {
		ACT_ST_IDLE  = 2'b00,
		ACT_ST_DELAY = 2'b01,
		ACT_ST_CONV  = 2'b10
	} act_state_t;

endpackage : act_pkg

//--- hdl/act_clkdiv.sv
// Conversion clock enable: divides the system clock or follows the RC oscillator.
// Assumes rc_osc_clk is asynchronous and much slower than clk.
`timescale 1ns/1ps
module act_clkdiv (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Control
	input  wire logic [2:0] conv_clock_select,
	input  wire logic       run,
	// RC oscillator pin
	input  wire logic       rc_osc_clk,
	// Tick out
	output logic            tad_tick
);
	import act_pkg::*;

	logic [5:0] cnt_r;
	logic       rc_s1_r;
	logic       rc_s2_r;
	logic       rc_prev_r;
	logic       use_rc;

	// Terminal count for each divider code
	function automatic logic [5:0] div_last(input logic [2:0] sel);
		case (sel)
			ACT_CS_DIV2:  div_last = 6'h01;
			ACT_CS_DIV4:  div_last = 6'h03;
			ACT_CS_DIV8:  div_last = 6'h07;
			ACT_CS_DIV16: div_last = 6'h0F;
			ACT_CS_DIV32: div_last = 6'h1F;
			ACT_CS_DIV64: div_last = 6'h3F;
			default:      div_last = 6'h01;
		endcase
	endfunction : div_last

	assign use_rc = (conv_clock_select[1:0] == ACT_CS_RC_LO);

	// ==========================================================
	// RC oscillator synchroniser and edge history
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rc_s1_r   <= 1'b0;
			rc_s2_r   <= 1'b0;
			rc_prev_r <= 1'b0;
		end else begin
			rc_s1_r   <= rc_osc_clk;
			rc_s2_r   <= rc_s1_r;
			rc_prev_r <= rc_s2_r;
		end
	end

	// ==========================================================
	// Divider; restarts when idle so the first period is whole
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= 6'h00;
		end else if (!run || use_rc || cnt_r >= div_last(conv_clock_select)) begin
			cnt_r <= 6'h00;
		end else begin
			cnt_r <= cnt_r + 6'h01;
		end
	end

	// One tick per conversion clock period
	always_comb begin
		if (!run) begin
			tad_tick = 1'b0;
		end else if (use_rc) begin
			tad_tick = rc_s2_r & ~rc_prev_r;
		end else begin
			tad_tick = (cnt_r >= div_last(conv_clock_select));
		end
	end

endmodule : act_clkdiv

//--- hdl/act_trig.sv
// Auto-conversion trigger: synchronises all sources and picks the selected rising edge.
// Assumes sources may be pins or other peripherals, so every one is synchronised.
`timescale 1ns/1ps
module act_trig (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    nrst,
	// Selection
	input  wire logic [4:0]              auto_trigger_select,
	input  wire logic                    allow,
	// Sources, index equals trigger code
	input  wire logic [act_pkg::ACT_TRIG_NUM-1:0] trig_src,
	// Event out
	output logic                         trig_pulse
);
	import act_pkg::*;

	logic [ACT_TRIG_NUM-1:0] s1_r;
	logic [ACT_TRIG_NUM-1:0] s2_r;
	logic [ACT_TRIG_NUM-1:0] prev_r;
	logic [ACT_TRIG_NUM-1:0] rise;
	logic                    code_ok;

	// ==========================================================
	// Two-stage synchroniser plus history for edge detection
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_r   <= '0;
			s2_r   <= '0;
			prev_r <= '0;
		end else begin
			s1_r   <= trig_src;
			s2_r   <= s1_r;
			prev_r <= s2_r;
		end
	end

	assign rise = s2_r & ~prev_r;

	// Code zero and the reserved codes yield nothing
	assign code_ok = (auto_trigger_select != ACT_TRIG_OFF) &&
	                 (auto_trigger_select <= ACT_TRIG_CELL4);

	// Codes 0x11 and 0x12 index the two logic cell outputs
	assign trig_pulse = allow && code_ok && rise[auto_trigger_select];

endmodule : act_trig

//--- tb/act_core_model.sv
// Partner model: analog core that counts ticks after start, then reports.
// Assumes the act_top request struct; sample is the value to convert.
// Sample stands for a pin already set to input and analog
`timescale 1ns/1ps
module act_core_model #(
	parameter int TICKS = 11
) (
	// Core link
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire act_pkg::act_core_req_t core_req,
	input  wire logic [9:0]             sample,
	output act_pkg::act_core_rsp_t      core_rsp
);
	import act_pkg::*;
	int         cnt_r;
	logic       done_r;
	logic [9:0] res_r;
	logic       last;
	// ==========================================================
	// Count restarts at each start; power off drops the conversion
	assign last = core_req.tad_tick && cnt_r == TICKS - 1;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_r  <= -1;
			done_r <= 1'b0;
			res_r  <= 10'h000;
		end else begin
			done_r <= last;
			if (last) res_r <= sample;
			if (core_req.start) cnt_r <= 0;
			else if (!core_req.powered || last) cnt_r <= -1;
			else if (core_req.tad_tick && cnt_r >= 0) cnt_r <= cnt_r + 1;
		end
	end
	// Result is shown only with done, never a stale copy
	assign core_rsp = '{done: done_r, result: done_r ? res_r : ~res_r};
endmodule : act_core_model

//--- tb/act_properties.sv
// Checker: register, start and completion relations at the act_top ports.
// Assumes one clock domain; attached by the bind after the module.
`timescale 1ns/1ps
module act_properties (
	// Register port and status
	input wire logic                   clk,
	input wire logic                   nrst,
	input wire logic [7:0]             addr,
	input wire logic [7:0]             wdata,
	input wire logic                   wr,
	input wire logic                   rd,
	input wire logic [7:0]             rdata,
	input wire logic                   sleep,
	input wire act_pkg::act_core_req_t core_req,
	input wire act_pkg::act_core_rsp_t core_rsp,
	input wire act_pkg::act_ref_t      ref_sel,
	input wire logic                   conversion_done_flag,
	input wire logic                   busy
);
	import act_pkg::*;
	logic rc_r;
	logic conv_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// ==========================================================
	// Helpers: RC clock chosen; core started and still busy
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rc_r   <= 1'b0;
			conv_r <= 1'b0;
		end else begin
			if (wr && addr == ACT_OFS_CTRL1) rc_r <= (wdata[5:4] == 2'b11);
			conv_r <= core_req.start | (conv_r & busy);
		end
	end
	sequence s_go_wr;
		wr && addr == ACT_OFS_CTRL0 && wdata[1:0] == 2'b11;
	endsequence
	sequence s_done;
		conv_r && busy && core_rsp.done && !sleep && !wr;
	endsequence
	// ==========================================================
	// Assertions
	a_ctrl1_pad_zero:
	assert property (rd && addr == ACT_OFS_CTRL1 |=> rdata[3:2] == 2'b00) else $error("pad");
	a_trig_pad_zero:
	assert property (rd && addr == ACT_OFS_TRIG |=> rdata[7:5] == 3'b000) else $error("pad");
	a_power_follows:
	assert property (wr && addr == ACT_OFS_CTRL0 |=> core_req.powered == $past(wdata[0]))
		else $error("power");
	a_ref_follows:
	assert property (wr && addr == ACT_OFS_CTRL1 |=> ref_sel == $past(wdata[1:0]))
		else $error("ref");
	a_go_refused:
	assert property (s_go_wr ##0 !core_req.powered |=> !busy) else $error("go taken");
	a_start_soon:
	assert property ($rose(busy) |-> ##[0:8] core_req.start) else $error("no start");
	a_rc_waits:
	assert property (rc_r && $rose(busy) |-> !core_req.start [*4]) else $error("rc early");
	a_done_ends:
	assert property (s_done |=> !busy && conversion_done_flag) else $error("no end");
endmodule : act_properties
bind act_top act_properties i_act_properties (
	.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
	.sleep(sleep), .core_req(core_req), .core_rsp(core_rsp), .ref_sel(ref_sel),
	.conversion_done_flag(conversion_done_flag), .busy(busy));

//--- tb/test_act_top.sv
// Testbench for act_top: registers, routing, conversions and triggers.
// Assumes act_core_model as the analog core; sleep rises only to cut a conversion.
`timescale 1ns/1ps
module test_act_top;
	import act_pkg::*;
	logic          clk, nrst, wr, rd, ext_osc_sel, sleep, rc_osc_clk, done_flag, busy;
	logic [7:0]    addr, wdata, rdata, d;
	logic [18:0]   trig_src;
	logic [9:0]    sample;
	act_core_req_t core_req;
	act_core_rsp_t core_rsp;
	act_route_t    route;
	act_ref_t      ref_sel;
	int            fail_count, tests_run;
	// ==========================================================
	// Design, core model and clocks (RC unrelated to clk)
	act_top i_act_top (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .ext_osc_sel(ext_osc_sel), .sleep(sleep), .rc_osc_clk(rc_osc_clk),
		.trig_src(trig_src), .core_req(core_req), .core_rsp(core_rsp), .route(route),
		.ref_sel(ref_sel), .conversion_done_flag(done_flag), .busy(busy));
	act_core_model i_act_core_model (.clk(clk), .nrst(nrst), .core_req(core_req),
		.sample(sample), .core_rsp(core_rsp));
	initial forever #10 clk = ~clk;
	initial forever #157 rc_osc_clk = ~rc_osc_clk;
	// ==========================================================
	// Compare, bus and wait tasks
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic final_report;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report
	// One idle edge after each write, so wr is never set twice in one step
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		@(posedge clk);
	endtask : rd_reg
	// Busy is sampled off the edge; a hang ends the run
	task automatic wait_idle;
		int n;
		@(negedge clk);
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
		@(posedge clk);
		if (n == 3000) begin
			chk("busy timeout", 8'h00, 8'h01);
			final_report();
		end
	endtask : wait_idle
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		for (int a = 0; a < 8; a++) begin
			rd_reg(8'(a));
			chk("reset", 8'h00, d);
		end
		wr_reg(ACT_OFS_CTRL1, 8'hFF);
		rd_reg(ACT_OFS_CTRL1);
		chk("ctrl1", 8'hF3, d);
		chk("ref_sel", 8'h03, 8'(ref_sel));
		wr_reg(ACT_OFS_TRIG, 8'hFF);
		rd_reg(ACT_OFS_TRIG);
		chk("trig", 8'h1F, d);
		wr_reg(8'h07, 8'hFF);
		rd_reg(8'h07);
		chk("unmapped", 8'h00, d);
		wr_reg(ACT_OFS_CTRL0, 8'h03);
		rd_reg(ACT_OFS_CTRL0);
		chk("go with on", 8'h01, d);
		$display("t_regs done");
	endtask : t_regs
	function automatic logic [7:0] exp_route(input logic [5:0] c, input logic x);
		if (c <= 6'h05 && !(x && c >= 6'h04)) return {5'h01, c[2:0]};
		if (c >= 6'h10 && c <= 6'h15) return {5'h02, c[2:0]};
		if (c >= 6'h3B) return {1'b0, 4'(7'h42 - 7'(c)), 3'h0};
		return 8'h00;
	endfunction : exp_route
	// Every channel class, with internal and external oscillator
	task automatic t_route;
		logic [5:0] ch [13] = '{6'h00, 6'h04, 6'h05, 6'h06, 6'h10, 6'h15, 6'h16,
			6'h3A, 6'h3B, 6'h3C, 6'h3D, 6'h3E, 6'h3F};
		logic [7:0] g;
		for (int x = 0; x < 2; x++) begin
			ext_osc_sel <= x[0];
			for (int i = 0; i < 13; i++) begin
				wr_reg(ACT_OFS_CTRL0, {ch[i], 2'b00});
				repeat (2) @(negedge clk);
				g = {1'b0, route.src, (route.src inside {ACT_SRC_PORTA, ACT_SRC_PORTC}) ?
					route.pin : 3'h0};
				chk("route", exp_route(ch[i], x[0]), g);
				@(posedge clk);
			end
		end
		$display("t_route done");
	endtask : t_route
	// One conversion per clock code, justification alternating
	task automatic t_conv;
		logic [2:0] cs [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
		logic [9:0] s;
		for (int i = 0; i < 8; i++) begin
			s = 10'h2A5 ^ 10'(i * 77);
			sample <= s;
			wr_reg(ACT_OFS_CTRL1, {i[0], cs[i], 4'h0});
			wr_reg(ACT_OFS_CTRL0, 8'h01);
			repeat (4) @(posedge clk);
			wr_reg(ACT_OFS_CTRL0, 8'h03);
			rd_reg(ACT_OFS_CTRL0);
			chk("go busy", 8'h03, d);
			wait_idle();
			chk("done flag", 8'h01, 8'(done_flag));
			rd_reg(ACT_OFS_CTRL0);
			chk("go clear", 8'h01, d);
			rd_reg(ACT_OFS_RES_HIGH);
			chk("res high", i[0] ? {6'h00, s[9:8]} : s[9:2], d);
			rd_reg(ACT_OFS_RES_LOW);
			chk("res low", i[0] ? s[7:0] : {s[1:0], 6'h00}, d);
			wr_reg(ACT_OFS_FLAGS, 8'h00);
			rd_reg(ACT_OFS_FLAGS);
			chk("flag clear", 8'h00, d);
		end
		$display("t_conv done");
	endtask : t_conv
	// Trigger codes: selected, wrong source, disabled, reserved
	task automatic t_trig;
		logic [4:0] code [6] = '{5'h11, 5'h12, 5'h12, 5'h00, 5'h13, 5'h10};
		int         src [6]  = '{17, 18, 17, 1, 18, 16};
		logic [7:0] hit [6]  = '{8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
		wr_reg(ACT_OFS_CTRL0, 8'h01);
		for (int i = 0; i < 6; i++) begin
			wr_reg(ACT_OFS_TRIG, {3'h0, code[i]});
			trig_src[src[i]] <= 1'b1;
			repeat (7) @(negedge clk);
			chk("trigger", hit[i], 8'(busy));
			wait_idle();
			trig_src[src[i]] <= 1'b0;
			repeat (8) @(negedge clk);
			chk("fall", 8'h00, 8'(busy));
			@(posedge clk);
		end
		$display("t_trig done");
	endtask : t_trig
	// Sleep on a divided clock, then power-off, each cut a conversion short
	task automatic t_abort;
		for (int k = 0; k < 2; k++) begin
			wr_reg(ACT_OFS_CTRL1, {1'b0, ACT_CS_DIV64, 4'h0});
			wr_reg(ACT_OFS_FLAGS, 8'h00);
			wr_reg(ACT_OFS_CTRL0, 8'h01);
			wr_reg(ACT_OFS_CTRL0, 8'h03);
			repeat (20) @(posedge clk);
			if (k == 0) begin
				sleep <= 1'b1;
			end else begin
				wr_reg(ACT_OFS_CTRL0, 8'h00);
			end
			repeat (3) @(negedge clk);
			chk("abort busy", 8'h00, 8'(busy));
			chk("abort flag", 8'h00, 8'(done_flag));
			@(posedge clk);
			sleep <= 1'b0;
		end
		$display("t_abort done");
	endtask : t_abort
	initial begin
		clk = 1'b0;
		rc_osc_clk = 1'b0;
		nrst = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		ext_osc_sel = 1'b0;
		sleep = 1'b0;
		trig_src = '0;
		sample = 10'h000;
		fail_count = 0;
		tests_run = 0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_route();
		t_conv();
		t_trig();
		t_abort();
		final_report();
	end
endmodule : test_act_top
